// >>> codec_pwr_defs.svh
// Command codes, field positions, reset values and timing figures of the codec power and tone block.
`ifndef CODEC_PWR_DEFS_SVH
`define CODEC_PWR_DEFS_SVH

// System clock rate in hertz.
`define CLK_HZ 25000000
// Length of one tone pattern unit in milliseconds.
`define TONE_UNIT_MS 100
// Tone frequency step per code value in hertz.
`define TONE_STEP_HZ 50
// Phase increment per frequency code for a 24-bit accumulator.
`define TONE_INC_PER_STEP (`TONE_STEP_HZ * (2 ** 24) / `CLK_HZ)

// Command address fields, compared against the top bits of a command byte.
`define AMP_ADDR 3'h0
`define RX2_ADDR 3'h6
`define WAKE_PAT 6'h1e
`define SLEEP_PAT 6'h1c
`define DGAIN_ADDR 4'h2
`define TGAIN_ADDR 3'h2
`define TONEA_ADDR 3'h4
`define TONEB_ADDR 3'h5
`define PATTERN_ADDR 4'he
`define TCTRL_ADDR 6'h3c

// Bit positions inside the amplifier power register.
`define AMP_MIC_BIT 4
`define AMP_AUXIN_BIT 3
`define AMP_REC1_BIT 2
`define AMP_AUXOUT_BIT 1
`define AMP_RING_BIT 0
// Receiver 2 power bit inside the send gain register.
`define RX2_ON_BIT 4

// Reset values.
`define AMP_RESET 5'h00
`define RX2_RESET 5'h00
`define TGAIN_RESET 5'h00
`define PATTERN_RESET 4'h0

// Tone gain code that selects the extra fixed low setting.
`define TGAIN_LOW_CODE 5'h1f

`endif

// >>> codec_pwr_pkg.sv
// Types shared by the codec power and tone block.
package codec_pwr_pkg;

  typedef enum logic [1:0] {
    TONE_IDLE,
    TONE_ON,
    TONE_OFF
  } tone_state_t;

endpackage : codec_pwr_pkg

// >>> tone_nco.sv
// Square-wave tone oscillator built from a phase accumulator.
module tone_nco (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_run,
  input wire logic [23:0] i_inc,
  output logic o_square
);

  logic [23:0] acc_ff;

  // The accumulator freezes while stopped so a restart resumes cleanly.
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      acc_ff <= 24'h000000;
    end else if (i_run) begin
      acc_ff <= acc_ff + i_inc;
    end
  end

  // The top bit of the phase is the square wave, registered once more.
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      o_square <= 1'b0;
    end else begin
      o_square <= i_run & acc_ff[23];
    end
  end

endmodule : tone_nco

// >>> codec_power_tone_outputs.sv
// Command decoder, power sequencing and ringer/timer outputs of the telephone codec.
// Contract
// (RQ1) Ringer square wave at tone frequency.
// (RQ2) Ringer buffer enabled by ringer power bit.
// (RQ3) Timer pin follows tone on/off pattern.
// (RQ4) Controller should use full tone gain.
// (RQ5) Single/dual tone, command-set frequency, pattern, start; the ringer carries tone A only, tone B reaches no pin.
// (RQ6) Special command starts three-frequency tone.
// (RQ7) Send digital gain 0 to -2.8 dB.
// (RQ8) Receive digital gain 0 to -2.4 dB.
// (RQ9) Tone gain 1 dB steps plus low setting.
// (RQ10) No input amplifier: pre-filter and ADC off.
// (RQ11) Accessory out and receiver 1 off: DAC off.
// (RQ12) Sleep command enters stand-by, wake leaves it.
// (RQ13) Address zero loads five amplifier power bits.
// (RQ14) Receiver 2 power lives in send gain register.
// (RQ15) Wake pattern 011110xx.
// (RQ16) Controller never powers mic and aux-in together.
// (RQ17) Sleep pattern 011100xx.
// (RQ18) Reset enters stand-by, clears amplifier register.
// (RQ19) Stand-by forces amplifiers off, keeps registers.
// (RQ20) Power bit one means amplifier on.
// (RQ21) Unknown commands leave power state alone.
`include "codec_pwr_defs.svh"

module codec_power_tone_outputs #(
  parameter int UNIT_CYCLES = `CLK_HZ / 1000 * `TONE_UNIT_MS,
  parameter logic [4:0] TRI_CODE0 = 5'h13,
  parameter logic [4:0] TRI_CODE1 = 5'h1c,
  parameter logic [4:0] TRI_CODE2 = 5'h24
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_cmd_clk,
  input wire logic i_cmd_data,
  input wire logic i_cmd_strobe,
  output logic o_standby,
  output logic o_mic_amp_on,
  output logic o_aux_in_amp_on,
  output logic o_receiver1_amp_on,
  output logic o_aux_out_amp_on,
  output logic o_receiver2_amp_on,
  output logic o_prefilter_on,
  output logic o_adc_on,
  output logic o_dac_on,
  output logic [3:0] o_send_analog_gain,
  output logic [2:0] o_send_dgain,
  output logic [1:0] o_recv_dgain,
  output logic [4:0] o_tone_gain,
  output logic o_ringer,
  output logic o_ringer_oe,
  output logic o_timer
);

  // Link side: reset, shift register and latched command byte.
  logic [1:0] link_rst_sync_ff;
  logic [7:0] shift_ff;
  logic [7:0] link_byte_ff;
  logic link_tgl_ff;

  // System side: toggle synchroniser and decoded command.
  logic tgl_meta_ff;
  logic tgl_sync_ff;
  logic tgl_seen_ff;
  logic cmd_fire;
  logic [7:0] cmd;

  // Registers written by commands.
  logic [4:0] amplifier_power_reg_ff;
  logic [4:0] send_gain_rx2_reg_ff;
  logic standby_ff;
  logic [2:0] send_dgain_ff;
  logic [1:0] recv_dgain_ff;
  logic [4:0] tone_gain_reg_ff;
  logic [4:0] tone_a_code_ff;
  logic [4:0] tone_b_code_ff;
  logic [3:0] pattern_ff;
  logic tone_start_ff;
  logic triple_ff;

  // Tone sequencing.
  codec_pwr_pkg::tone_state_t tone_state_ff;
  codec_pwr_pkg::tone_state_t nxt_tone_state;
  logic [21:0] unit_cnt_ff;
  logic unit_tick;
  logic [2:0] phase_cnt_ff;
  logic [1:0] tri_step_ff;
  logic tone_run;
  logic [4:0] code_a;
  logic [1:0] square;
  logic [23:0] inc [2];

  // The reset pin belongs to the system clock, so it is resynchronised before the link logic uses it.
  always_ff @(posedge i_cmd_clk) begin
    link_rst_sync_ff <= {link_rst_sync_ff[0], i_reset_n};
  end

  // Bits arrive least significant first; a strobe at a clock edge latches the byte and flips the toggle.
  always_ff @(posedge i_cmd_clk) begin
    if (!link_rst_sync_ff[1]) begin
      shift_ff <= 8'h00;
      link_byte_ff <= 8'h00;
      link_tgl_ff <= 1'b0;
    end else if (i_cmd_strobe) begin
      link_byte_ff <= shift_ff;
      link_tgl_ff <= ~link_tgl_ff;
    end else begin
      shift_ff <= {i_cmd_data, shift_ff[7:1]};
    end
  end

  // The toggle crosses by two flip-flops; the byte is stable long before the toggle lands.
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      tgl_meta_ff <= 1'b0;
      tgl_sync_ff <= 1'b0;
      tgl_seen_ff <= 1'b0;
    end else begin
      tgl_meta_ff <= link_tgl_ff;
      tgl_sync_ff <= tgl_meta_ff;
      tgl_seen_ff <= tgl_sync_ff;
    end
  end

  assign cmd_fire = tgl_sync_ff ^ tgl_seen_ff;
  assign cmd = link_byte_ff;

  // Power register loads; all other addresses leave them untouched.
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      amplifier_power_reg_ff <= `AMP_RESET; // RQ18
      send_gain_rx2_reg_ff <= `RX2_RESET;
    end else if (cmd_fire) begin
      if (cmd[7:5] == `AMP_ADDR) begin
        amplifier_power_reg_ff <= cmd[4:0]; // RQ13
      end
      if (cmd[7:5] == `RX2_ADDR) begin
        send_gain_rx2_reg_ff <= cmd[4:0]; // RQ14
      end
    end
  end

  // Stand-by is a single flag; the low two command bits are ignored for both patterns.
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      standby_ff <= 1'b1; // RQ18
    end else if (cmd_fire && cmd[7:2] == `SLEEP_PAT) begin
      standby_ff <= 1'b1; // RQ17 RQ12
    end else if (cmd_fire && cmd[7:2] == `WAKE_PAT) begin
      standby_ff <= 1'b0; // RQ15 RQ12
    end
  end

  // Digital gain codes: one step of the code is one documented gain step.
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      send_dgain_ff <= 3'h0;
      recv_dgain_ff <= 2'h0;
      tone_gain_reg_ff <= `TGAIN_RESET;
    end else if (cmd_fire) begin
      if (cmd[7:4] == `DGAIN_ADDR && !cmd[3]) begin
        send_dgain_ff <= cmd[2:0]; // RQ7
      end
      if (cmd[7:4] == `DGAIN_ADDR && cmd[3]) begin
        recv_dgain_ff <= cmd[1:0]; // RQ8
      end
      if (cmd[7:5] == `TGAIN_ADDR) begin
        tone_gain_reg_ff <= cmd[4:0]; // RQ9
      end
    end
  end

  // Tone frequency, pattern and start commands.
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      tone_a_code_ff <= 5'h00;
      tone_b_code_ff <= 5'h00;
      pattern_ff <= `PATTERN_RESET;
      tone_start_ff <= 1'b0;
      triple_ff <= 1'b0;
    end else if (cmd_fire) begin
      if (cmd[7:5] == `TONEA_ADDR) begin
        tone_a_code_ff <= cmd[4:0]; // RQ5
      end
      if (cmd[7:5] == `TONEB_ADDR) begin
        tone_b_code_ff <= cmd[4:0]; // RQ5
      end
      if (cmd[7:4] == `PATTERN_ADDR) begin
        pattern_ff <= cmd[3:0]; // RQ5
      end
      if (cmd[7:2] == `TCTRL_ADDR) begin
        tone_start_ff <= cmd[0]; // RQ5
        triple_ff <= cmd[1]; // RQ6
      end
    end
  end

  // Pattern unit timer; it is held still in stand-by, where the oscillators halt as well.
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n || tone_state_ff == codec_pwr_pkg::TONE_IDLE) begin
      unit_cnt_ff <= 22'h000000;
    end else if (!standby_ff) begin
      unit_cnt_ff <= unit_tick ? 22'h000000 : unit_cnt_ff + 22'h000001;
    end
  end

  assign unit_tick = !standby_ff && unit_cnt_ff == 22'(UNIT_CYCLES - 1);

  // On time is one to four units; an off time of zero gives a continuous tone.
  always_comb begin
    nxt_tone_state = tone_state_ff;
    case (tone_state_ff)
      codec_pwr_pkg::TONE_IDLE: begin
        if (tone_start_ff) begin
          nxt_tone_state = codec_pwr_pkg::TONE_ON;
        end
      end
      codec_pwr_pkg::TONE_ON: begin
        if (!tone_start_ff) begin
          nxt_tone_state = codec_pwr_pkg::TONE_IDLE;
        end else if (unit_tick && phase_cnt_ff == {1'b0, pattern_ff[3:2]} && pattern_ff[1:0] != 2'h0) begin
          nxt_tone_state = codec_pwr_pkg::TONE_OFF; // RQ5
        end
      end
      codec_pwr_pkg::TONE_OFF: begin
        if (!tone_start_ff) begin
          nxt_tone_state = codec_pwr_pkg::TONE_IDLE;
        end else if (unit_tick && phase_cnt_ff == {1'b0, pattern_ff[1:0]} - 3'h1) begin
          nxt_tone_state = codec_pwr_pkg::TONE_ON;
        end
      end
      default: begin
        nxt_tone_state = codec_pwr_pkg::TONE_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      tone_state_ff <= codec_pwr_pkg::TONE_IDLE;
    end else begin
      tone_state_ff <= nxt_tone_state;
    end
  end

  // Units spent in the present phase; restarts whenever the phase changes.
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n || nxt_tone_state != tone_state_ff) begin
      phase_cnt_ff <= 3'h0;
    end else if (unit_tick && tone_state_ff == codec_pwr_pkg::TONE_ON && pattern_ff[1:0] == 2'h0) begin
      phase_cnt_ff <= 3'h0;
    end else if (unit_tick) begin
      phase_cnt_ff <= phase_cnt_ff + 3'h1;
    end
  end

  // Three-frequency tone walks through its codes one unit each, then rests one unit.
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n || !triple_ff || tone_state_ff == codec_pwr_pkg::TONE_IDLE) begin
      tri_step_ff <= 2'h0;
    end else if (unit_tick) begin
      tri_step_ff <= tri_step_ff + 2'h1; // RQ6
    end
  end

  always_comb begin
    case (tri_step_ff)
      2'h0: code_a = TRI_CODE0;
      2'h1: code_a = TRI_CODE1;
      2'h2: code_a = TRI_CODE2;
      default: code_a = 5'h00;
    endcase
    if (!triple_ff) begin
      code_a = tone_a_code_ff;
    end
  end

  // Oscillators stop in stand-by, in the off phase and in the rest unit of the triple tone.
  // A zero code alone would only freeze the phase, which can leave the ringer stuck high.
  assign tone_run = !standby_ff && tone_state_ff == codec_pwr_pkg::TONE_ON && !(triple_ff && tri_step_ff == 2'h3); // RQ6
  assign inc[0] = 24'(code_a * `TONE_INC_PER_STEP);
  assign inc[1] = 24'(tone_b_code_ff * `TONE_INC_PER_STEP);

  // One oscillator per tone; only the first drives the ringer, so the second tone never reaches a pin.
  for (genvar ch = 0; ch < 2; ch++) begin : g_tone
    tone_nco u_nco (
      .i_sys_clk(i_sys_clk),
      .i_reset_n(i_reset_n),
      .i_run(tone_run),
      .i_inc(inc[ch]),
      .o_square(square[ch])
    );
  end

  // Amplifier enables; stand-by overrides every bit but the register keeps its value.
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      o_standby <= 1'b1;
      o_mic_amp_on <= 1'b0;
      o_aux_in_amp_on <= 1'b0;
      o_receiver1_amp_on <= 1'b0;
      o_aux_out_amp_on <= 1'b0;
      o_receiver2_amp_on <= 1'b0;
      o_prefilter_on <= 1'b0;
      o_adc_on <= 1'b0;
      o_dac_on <= 1'b0;
    end else begin
      o_standby <= standby_ff;
      o_mic_amp_on <= !standby_ff && amplifier_power_reg_ff[`AMP_MIC_BIT]; // RQ19 RQ20
      o_aux_in_amp_on <= !standby_ff && amplifier_power_reg_ff[`AMP_AUXIN_BIT]; // RQ19 RQ20
      o_receiver1_amp_on <= !standby_ff && amplifier_power_reg_ff[`AMP_REC1_BIT]; // RQ19 RQ20
      o_aux_out_amp_on <= !standby_ff && amplifier_power_reg_ff[`AMP_AUXOUT_BIT]; // RQ19 RQ20
      o_receiver2_amp_on <= !standby_ff && send_gain_rx2_reg_ff[`RX2_ON_BIT]; // RQ14 RQ19
      o_prefilter_on <= !standby_ff && |amplifier_power_reg_ff[`AMP_MIC_BIT:`AMP_AUXIN_BIT]; // RQ10
      o_adc_on <= !standby_ff && |amplifier_power_reg_ff[`AMP_MIC_BIT:`AMP_AUXIN_BIT]; // RQ10
      o_dac_on <= !standby_ff && |amplifier_power_reg_ff[`AMP_REC1_BIT:`AMP_AUXOUT_BIT]; // RQ11
    end
  end

  // Gain settings toward the signal processor, which multiplies by the matching coefficient.
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      o_send_analog_gain <= 4'h0;
      o_send_dgain <= 3'h0;
      o_recv_dgain <= 2'h0;
      o_tone_gain <= `TGAIN_RESET;
    end else begin
      o_send_analog_gain <= send_gain_rx2_reg_ff[3:0];
      o_send_dgain <= send_dgain_ff; // RQ7
      o_recv_dgain <= recv_dgain_ff; // RQ8
      o_tone_gain <= tone_gain_reg_ff; // RQ9
    end
  end

  // Ringer and timer pins; the ringer buffer is unpowered unless its bit is set outside stand-by.
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      o_ringer <= 1'b0;
      o_ringer_oe <= 1'b0;
      o_timer <= 1'b0;
    end else begin
      o_ringer <= square[0]; // RQ1
      o_ringer_oe <= !standby_ff && amplifier_power_reg_ff[`AMP_RING_BIT]; // RQ2
      o_timer <= tone_run; // RQ3
    end
  end

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_reset_n);

  sequence s_wake_cmd;
    cmd_fire && cmd[7:2] == `WAKE_PAT;
  endsequence

  sequence s_sleep_cmd;
    cmd_fire && cmd[7:2] == `SLEEP_PAT;
  endsequence

  a_wake_clears_standby: assert property (s_wake_cmd |=> !standby_ff ##1 !o_standby) // RQ15
    else $error("wake command did not leave stand-by");
  a_sleep_sets_standby: assert property (s_sleep_cmd |=> standby_ff ##1 o_standby) // RQ17
    else $error("sleep command did not enter stand-by");
  a_amp_reg_load: assert property (cmd_fire && cmd[7:5] == 3'h0 |=> amplifier_power_reg_ff == $past(cmd[4:0])) // RQ13
    else $error("amplifier power register not loaded");
  a_rx2_power_follow: assert property (cmd_fire && cmd[7:5] == 3'h6 && cmd[4] && !standby_ff
    ##1 !cmd_fire |=> o_receiver2_amp_on) // RQ14
    else $error("receiver 2 not powered after its bit was set");
  a_unknown_cmd_hold: assert property (cmd_fire && cmd[7:5] != 3'h0 && cmd[7:5] != 3'h6
    && cmd[7:2] != `WAKE_PAT && cmd[7:2] != `SLEEP_PAT
    |=> $stable(amplifier_power_reg_ff) && $stable(send_gain_rx2_reg_ff) && $stable(standby_ff)) // RQ21
    else $error("unmapped command changed power state");
  a_standby_amps_off: assert property (standby_ff |=> !o_mic_amp_on && !o_aux_in_amp_on && !o_receiver1_amp_on
    && !o_aux_out_amp_on && !o_receiver2_amp_on && !o_ringer_oe) // RQ19
    else $error("amplifier powered in stand-by");
  a_adc_needs_input: assert property (o_adc_on |-> o_mic_amp_on || o_aux_in_amp_on) // RQ10
    else $error("converter powered with no input amplifier");
  a_dac_needs_output: assert property (!o_aux_out_amp_on && !o_receiver1_amp_on |-> !o_dac_on) // RQ11
    else $error("output converter powered with its amplifiers off");
  a_ringer_buffer_bit: assert property (!standby_ff && amplifier_power_reg_ff[0] |=> o_ringer_oe) // RQ2
    else $error("ringer buffer not enabled by its bit");
  a_timer_idle_low: assert property (tone_state_ff != codec_pwr_pkg::TONE_ON ##1 1 |-> !o_timer) // RQ3
    else $error("timer pin high outside the on phase");
  a_ringer_quiet_off: assert property (!tone_run ##1 !tone_run |=> !o_ringer) // RQ1
    else $error("ringer toggles while the tone is stopped");
  a_reset_state: assert property (disable iff (1'b0) $rose(i_reset_n) |-> standby_ff
    && amplifier_power_reg_ff == 5'h00) // RQ18
    else $error("reset did not enter stand-by with a cleared register");

endmodule : codec_power_tone_outputs

// >>> cmd_link_model.sv
// Controller model that sends serial commands over the command link.
module cmd_link_model (
  output logic o_cmd_clk,
  output logic o_cmd_data,
  output logic o_cmd_strobe
);
  timeunit 1ns;
  timeprecision 1ps;

  // The link clock stands low between frames, as a real controller leaves it.
  initial begin
    o_cmd_clk = 1'b0;
    o_cmd_data = 1'b0;
    o_cmd_strobe = 1'b0;
  end

  // One 30 ns link clock period; data and strobe only move while the clock is low.
  task automatic pulse();
    #15 o_cmd_clk = 1'b1;
    #15 o_cmd_clk = 1'b0;
  endtask : pulse

  // Free edges with strobe low, needed to clear the link side reset copy.
  task automatic idle_clocks(input int n);
    repeat (n) pulse();
  endtask : idle_clocks

  // Sends one byte first bit D0, then the strobe edge that latches it.
  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      o_cmd_data = b[i];
      pulse();
    end
    o_cmd_strobe = 1'b1;
    pulse();
    o_cmd_strobe = 1'b0;
    // The line is not held after the frame, so it shows no stale bit.
    o_cmd_data = ~b[7];
  endtask : send_byte
endmodule : cmd_link_model

// >>> codec_power_tone_outputs_tb.sv
// Self-checking bench for the codec power and tone block.
module codec_power_tone_outputs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int UNIT = 40;
  logic sys_clk;
  logic reset_n;
  wire cmd_clk;
  wire cmd_data;
  wire cmd_strobe;
  logic o_standby, o_mic, o_auxin, o_rec1, o_auxout, o_rx2, o_pre, o_adc, o_dac;
  logic [3:0] o_sag;
  logic [2:0] o_sdg;
  logic [1:0] o_rdg;
  logic [4:0] o_tg;
  logic o_ringer, o_ringer_oe, o_timer;
  logic [9:0] pwr;
  logic [4:0] amp_val;
  logic rx2_val;
  int fails;
  int cmp_count;

  // All power outputs in one vector so one compare covers the whole state.
  assign pwr = {o_standby, o_mic, o_auxin, o_rec1, o_auxout, o_rx2, o_pre, o_adc, o_dac, o_ringer_oe};

  codec_power_tone_outputs #(.UNIT_CYCLES(UNIT)) uut (
    .i_sys_clk(sys_clk), .i_reset_n(reset_n), .i_cmd_clk(cmd_clk), .i_cmd_data(cmd_data),
    .i_cmd_strobe(cmd_strobe), .o_standby(o_standby), .o_mic_amp_on(o_mic), .o_aux_in_amp_on(o_auxin),
    .o_receiver1_amp_on(o_rec1), .o_aux_out_amp_on(o_auxout), .o_receiver2_amp_on(o_rx2),
    .o_prefilter_on(o_pre), .o_adc_on(o_adc), .o_dac_on(o_dac), .o_send_analog_gain(o_sag),
    .o_send_dgain(o_sdg), .o_recv_dgain(o_rdg), .o_tone_gain(o_tg), .o_ringer(o_ringer),
    .o_ringer_oe(o_ringer_oe), .o_timer(o_timer));

  cmd_link_model link (.o_cmd_clk(cmd_clk), .o_cmd_data(cmd_data), .o_cmd_strobe(cmd_strobe));

  // The 25 MHz system clock.
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Compares a design value with its expected value.
  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Compares a measured span in cycles with its allowed range.
  task automatic chk_span(input string what, input int lo, input int hi, input int got);
    cmp_count++;
    if (got < lo || got > hi) begin
      fails++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : chk_span

  // Expected power outputs; stand-by wins over every register bit.
  function automatic logic [9:0] pwr_exp(input logic s, input logic [4:0] a, input logic r);
    if (s) begin
      return 10'h200;
    end
    return {1'b0, a[4:1], r, a[4] | a[3], a[4] | a[3], a[2] | a[1], a[0]};
  endfunction : pwr_exp

  // Sends one command and waits out the fixed decode latency plus margin.
  task automatic cmd(input logic [7:0] b);
    link.send_byte(b);
    repeat (8) @(negedge sys_clk);
  endtask : cmd

  // Counts cycles while the chosen output stays at a level, bounded so a stuck pin cannot hang.
  task automatic span(input logic use_ring, input logic lvl, output int n);
    n = 0;
    while (((use_ring ? o_ringer : o_timer) === lvl) && n < 40000) begin
      @(negedge sys_clk);
      n++;
    end
  endtask : span

  task automatic test_reset();
    chk("reset power", 10'h200, pwr);
    chk("reset tone gain", 10'h0, 10'(o_tg));
    chk("reset timer", 10'h0, {o_ringer, o_timer});
    $display("test_reset done");
  endtask : test_reset

  task automatic test_wake_sleep();
    cmd(8'h7b);
    chk("wake low bits set", pwr_exp(0, 0, 0), pwr);
    cmd(8'h70);
    chk("sleep", 10'h200, pwr);
    cmd(8'h78);
    chk("wake", pwr_exp(0, 0, 0), pwr);
    cmd(8'h73);
    chk("sleep low bits set", 10'h200, pwr);
    cmd(8'h7a);
    $display("test_wake_sleep done");
  endtask : test_wake_sleep

  task automatic test_amp();
    // Mic and aux-in are never powered together, as the controller must avoid it.
    for (int i = 0; i < 32; i++) begin
      if (i < 24) begin
        amp_val = 5'(i);
        cmd({3'h0, amp_val});
        chk("amp power", pwr_exp(0, amp_val, 0), pwr);
      end
    end
    $display("test_amp done");
  endtask : test_amp

  task automatic test_rx2_hold();
    amp_val = 5'h17;
    cmd(8'h17);
    cmd(8'hd5);
    rx2_val = 1'b1;
    chk("rx2 on", pwr_exp(0, amp_val, 1), pwr);
    chk("send analog gain", 10'h5, 10'(o_sag));
    cmd(8'h70);
    chk("stand-by forces off", 10'h200, pwr);
    cmd(8'h78);
    chk("settings resume", pwr_exp(0, amp_val, 1), pwr);
    // Commands outside every power address must leave the state alone.
    cmd(8'h74);
    chk("unmapped command", pwr_exp(0, amp_val, 1), pwr);
    cmd(8'h7c);
    chk("unmapped command", pwr_exp(0, amp_val, 1), pwr);
    cmd(8'h60);
    chk("unmapped command", pwr_exp(0, amp_val, 1), pwr);
    cmd(8'h64);
    chk("unmapped command", pwr_exp(0, amp_val, 1), pwr);
    cmd(8'hca);
    chk("rx2 off", pwr_exp(0, amp_val, 0), pwr);
    chk("send analog gain", 10'ha, 10'(o_sag));
    $display("test_rx2_hold done");
  endtask : test_rx2_hold

  task automatic test_gains();
    cmd(8'h27);
    chk("send dgain max", 10'h7, 10'(o_sdg));
    cmd(8'h2f);
    chk("recv dgain max", 10'h3, 10'(o_rdg));
    cmd(8'h5e);
    chk("tone gain -30", 10'h1e, 10'(o_tg));
    cmd(8'h5f);
    chk("tone gain low", 10'h1f, 10'(o_tg));
    $display("test_gains done");
  endtask : test_gains

  task automatic test_tone();
    int n;
    int hi;
    int lo;
    cmd(8'h01);
    cmd(8'h40);
    cmd(8'h9f);
    cmd(8'ha0);
    cmd(8'he0);
    cmd(8'hf1);
    // Code 31 gives about 1524 Hz, a half period near 8200 cycles.
    span(1'b1, 1'b0, n);
    span(1'b1, 1'b1, hi);
    span(1'b1, 1'b0, lo);
    chk_span("ringer high", 7660, 8470, hi);
    chk_span("ringer low", 7660, 8470, lo);
    chk("timer continuous", 10'h3, {o_timer, o_ringer_oe});
    cmd(8'hf0);
    cmd(8'he5);
    cmd(8'hf1);
    span(1'b0, 1'b1, n);
    repeat (4) @(negedge sys_clk);
    chk("ringer in gap", 10'h0, 10'(o_ringer));
    span(1'b0, 1'b0, lo);
    span(1'b0, 1'b1, hi);
    chk_span("timer off", UNIT - 6, UNIT, lo);
    chk_span("timer on", 2 * UNIT - 2, 2 * UNIT + 2, hi);
    cmd(8'hf0);
    // A continuous pattern lets the triple tone's own rest unit show on the timer.
    cmd(8'he0);
    cmd(8'hf3);
    span(1'b0, 1'b1, n);
    span(1'b0, 1'b0, lo);
    span(1'b0, 1'b1, hi);
    chk_span("triple silent", UNIT - 2, UNIT + 2, lo);
    chk_span("triple on", 3 * UNIT - 2, 3 * UNIT + 2, hi);
    cmd(8'hf0);
    chk("stopped", 10'h0, {o_timer, o_ringer});
    $display("test_tone done");
  endtask : test_tone

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  // Cuts a hung run short; the tests need about 26000 cycles.
  initial begin
    repeat (80000) @(posedge sys_clk);
    fails++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    print_verdict();
  end

  // Link clock keeps running through reset so its reset copy clears.
  initial begin
    reset_n = 1'b0;
    fails = 0;
    cmp_count = 0;
    amp_val = 5'h00;
    rx2_val = 1'b0;
    fork
      link.idle_clocks(20);
      begin
        repeat (10) @(negedge sys_clk);
        reset_n = 1'b1;
      end
    join
    test_reset();
    test_wake_sleep();
    test_amp();
    test_rx2_hold();
    test_gains();
    test_tone();
    print_verdict();
  end
endmodule : codec_power_tone_outputs_tb
